// File: rtl/gbc_params.svh
`ifndef GBC_PARAMS_SVH
`define GBC_PARAMS_SVH
`define GBC_CMD_GO_LOCAL      7'h01
`define GBC_CMD_SEL_CLEAR     7'h04
`define GBC_CMD_GROUP_TRIG    7'h08
`define GBC_CMD_LOCKOUT       7'h11
`define GBC_CMD_DEV_CLEAR     7'h14
`define GBC_CMD_POLL_ENABLE   7'h18
`define GBC_CMD_POLL_DISABLE  7'h19
`define GBC_CMD_UNLISTEN      7'h3F
`define GBC_CMD_UNTALK        7'h5F
`define GBC_GRP_MSB           6
`define GBC_GRP_LSB           5
`define GBC_GRP_COMMAND       2'h0
`define GBC_GRP_LISTEN        2'h1
`define GBC_GRP_TALK          2'h2
`define GBC_GRP_SECONDARY     2'h3
`define GBC_ADDR_MSB          4
`define GBC_CMD_MSB           6
`define GBC_SYNC_RESET        3'h0
`define GBC_DEFAULT_ADDR      5'h0_C
`endif

// File: rtl/gbc_pkg.sv
package gbc_pkg;
  typedef enum logic [1:0] {
    GBC_HS_IDLE  = 2'b00,
    GBC_HS_TAKEN = 2'b01,
    GBC_HS_WAIT  = 2'b10
  } gbc_hs_state_t;

  typedef struct packed {
    logic       atn;
    logic       ifc;
    logic       ren;
    logic       eoi;
    logic       dav;
  } gbc_mgmt_t;

  typedef struct packed {
    logic [7:0] data;
    logic       eoi;
  } gbc_byte_t;
endpackage

// File: rtl/gbc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module gbc_sync #(
  parameter int WIDTH = 13
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] din,
  output var  logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;
  logic [WIDTH-1:0] out_reg;
  logic [WIDTH-1:0] out_next;

  if (WIDTH < 1) begin : g_bad_width
    $error("gbc_sync width must be positive");
  end

  // a change counts once the second and third stages agree
  always_comb begin
    out_next = out_reg;
    for (int i = 0; i < WIDTH; i++) begin
      if (s2_reg[i] == s3_reg[i]) begin
        out_next[i] = s3_reg[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s1_reg  <= '1;
      s2_reg  <= '1;
      s3_reg  <= '1;
      out_reg <= '1;
    end else begin
      s1_reg  <= din;
      s2_reg  <= s1_reg;
      s3_reg  <= s2_reg;
      out_reg <= out_next;
    end
  end

  assign dout = out_reg;
endmodule
`default_nettype wire

// File: rtl/gbc_decoder.sv
// Summary of operation
// - device pulls service request low when it needs attention
// - the sourcing party marks the final byte with end-or-identify
// - remote enable asserted with attention high puts the device into remote operation
// - interface clear drops talk and listen addressing
// - attention low bytes are commands; attention high bytes are data
// - universal commands act at once without addressing
// - local lockout (11) disables front panel controls
// - device clear (14) returns device to its power-up state
// - serial poll enable (18) enters serial poll mode
// - serial poll disable (19) leaves serial poll mode
// - addressed commands are obeyed only while addressed to listen
// - selective device clear (04) when listening acts like device clear
// - go-to-local (01) when listening leaves remote and releases lockout
// - group execute trigger (08) fires the trigger, optionally unaddressed
// - unlisten (3F) drops listener state
// - untalk (5F) drops talker state
// - listen addresses 20..3F carry primary address in low five bits
// - talk addresses 40..5F with matching address make device talker
// - secondary command group bytes are ignored
// - top data bit is don't-care when decoding commands
// - attention high bytes are forwarded to the command parser only while addressed to listen
// - every bus line is active low
// - not-data-accepted released only after byte latched while valid
`timescale 1ns/1ps
`default_nettype none
`include "gbc_params.svh"
module gbc_decoder #(
  parameter bit TRIG_UNADDRESSED = 1'b0
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [7:0]       dio_n_in,
  input  wire logic             atn_n,
  input  wire logic             ifc_n,
  input  wire logic             ren_n,
  input  wire logic             eoi_n_in,
  input  wire logic             dav_n,
  output logic                  nrfd_n_out,
  output logic                  nrfd_n_oe,
  output logic                  ndac_n_out,
  output logic                  ndac_n_oe,
  output logic                  srq_n_out,
  output logic                  srq_n_oe,
  input  wire logic [4:0]       primary_addr,
  input  wire logic             service_req,
  input  wire logic             parser_ready,
  output logic                  data_valid,
  output gbc_pkg::gbc_byte_t    data_out,
  output logic                  remote,
  output logic                  lockout,
  output logic                  listener,
  output logic                  talker,
  output logic                  serial_poll,
  output logic                  dev_clear,
  output logic                  trigger
);
  localparam int SYNC_W = 13;
  logic [SYNC_W-1:0]      sync_in;
  logic [SYNC_W-1:0]      sync_out;
  gbc_pkg::gbc_mgmt_t     mg;
  logic [7:0]             bus_data;
  logic                   bus_eoi;

  gbc_pkg::gbc_hs_state_t hs_reg;
  gbc_pkg::gbc_hs_state_t hs_next;
  logic [7:0]             byte_reg;
  logic [7:0]             byte_next;
  logic                   atn_reg;
  logic                   atn_next;
  logic                   eoi_reg;
  logic                   eoi_next;
  logic                   decode_go;

  logic                   remote_reg;
  logic                   remote_next;
  logic                   lockout_reg;
  logic                   lockout_next;
  logic                   listen_reg;
  logic                   listen_next;
  logic                   talk_reg;
  logic                   talk_next;
  logic                   spoll_reg;
  logic                   spoll_next;
  logic                   clear_reg;
  logic                   clear_next;
  logic                   trig_reg;
  logic                   trig_next;
  logic                   dvalid_reg;
  logic                   dvalid_next;
  gbc_pkg::gbc_byte_t     dout_reg;
  gbc_pkg::gbc_byte_t     dout_next;

  // all bus lines active low: invert once to active-high levels
  assign sync_in = {dio_n_in, atn_n, ifc_n, ren_n, eoi_n_in, dav_n};

  gbc_sync #(
    .WIDTH (SYNC_W)
  ) u_sync (
    .clk  (clk),
    .rst  (rst),
    .din  (sync_in),
    .dout (sync_out)
  );

  assign bus_data = ~sync_out[12:5];
  assign mg.atn   = ~sync_out[4];
  assign mg.ifc   = ~sync_out[3];
  assign mg.ren   = ~sync_out[2];
  assign mg.eoi   = ~sync_out[1];
  assign mg.dav   = ~sync_out[0];
  assign bus_eoi  = mg.eoi;

  function automatic logic [1:0] grp_of(input logic [7:0] b);
    grp_of = b[`GBC_GRP_MSB:`GBC_GRP_LSB];
  endfunction

  function automatic logic addr_hit(input logic [7:0] b,
                                    input logic [4:0] a);
    addr_hit = (b[`GBC_ADDR_MSB:0] == a);
  endfunction

  // acceptor handshake: hold off while a data byte awaits the parser
  always_comb begin
    hs_next   = hs_reg;
    byte_next = byte_reg;
    atn_next  = atn_reg;
    eoi_next  = eoi_reg;
    decode_go = 1'b0;
    case (hs_reg)
      gbc_pkg::GBC_HS_IDLE: begin
        if (mg.dav && (mg.atn || !dvalid_reg)) begin
          byte_next = bus_data;
          atn_next  = mg.atn;
          eoi_next  = bus_eoi;
          hs_next   = gbc_pkg::GBC_HS_TAKEN;
        end
      end
      gbc_pkg::GBC_HS_TAKEN: begin
        decode_go = 1'b1;
        hs_next   = gbc_pkg::GBC_HS_WAIT;
      end
      gbc_pkg::GBC_HS_WAIT: begin
        if (!mg.dav) begin
          hs_next = gbc_pkg::GBC_HS_IDLE;
        end
      end
      default: hs_next = gbc_pkg::GBC_HS_IDLE;
    endcase
  end

  // command interpreter
  always_comb begin
    logic [6:0] code;
    code         = byte_reg[`GBC_CMD_MSB:0];
    remote_next  = mg.ren ? remote_reg : 1'b0;
    lockout_next = mg.ren ? lockout_reg : 1'b0;
    listen_next  = listen_reg;
    talk_next    = talk_reg;
    spoll_next   = spoll_reg;
    clear_next   = 1'b0;
    trig_next    = 1'b0;
    dvalid_next  = dvalid_reg && !parser_ready;
    dout_next    = dout_reg;
    if (mg.ren && !remote_reg && !mg.atn) begin
      remote_next = 1'b1;
    end
    if (decode_go && atn_reg) begin
      case (grp_of(byte_reg))
        `GBC_GRP_COMMAND: begin
          case (code)
            `GBC_CMD_LOCKOUT: lockout_next = 1'b1;
            `GBC_CMD_DEV_CLEAR: clear_next = 1'b1;
            `GBC_CMD_POLL_ENABLE: spoll_next = 1'b1;
            `GBC_CMD_POLL_DISABLE: spoll_next = 1'b0;
            `GBC_CMD_SEL_CLEAR: clear_next = listen_reg;
            `GBC_CMD_GO_LOCAL: begin
              if (listen_reg) begin
                remote_next  = 1'b0;
                lockout_next = 1'b0;
              end
            end
            `GBC_CMD_GROUP_TRIG:
              trig_next = listen_reg || TRIG_UNADDRESSED;
            default: ;
          endcase
        end
        `GBC_GRP_LISTEN: begin
          if (code == `GBC_CMD_UNLISTEN) begin
            listen_next = 1'b0;
          end else if (addr_hit(byte_reg, primary_addr)) begin
            listen_next = 1'b1;
          end
        end
        `GBC_GRP_TALK: begin
          if (code == `GBC_CMD_UNTALK) begin
            talk_next = 1'b0;
          end else if (addr_hit(byte_reg, primary_addr)) begin
            talk_next = 1'b1;
          end else begin
            talk_next = 1'b0;
          end
        end
        default: ;
      endcase
    end
    if (decode_go && !atn_reg && listen_reg) begin
      dvalid_next    = 1'b1;
      dout_next.data = byte_reg;
      dout_next.eoi  = eoi_reg;
    end
    if (mg.ifc) begin
      listen_next = 1'b0;
      talk_next   = 1'b0;
      spoll_next  = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      hs_reg      <= gbc_pkg::GBC_HS_IDLE;
      byte_reg    <= '0;
      atn_reg     <= 1'b0;
      eoi_reg     <= 1'b0;
      remote_reg  <= 1'b0;
      lockout_reg <= 1'b0;
      listen_reg  <= 1'b0;
      talk_reg    <= 1'b0;
      spoll_reg   <= 1'b0;
      clear_reg   <= 1'b0;
      trig_reg    <= 1'b0;
      dvalid_reg  <= 1'b0;
      dout_reg    <= '0;
    end else begin
      hs_reg      <= hs_next;
      byte_reg    <= byte_next;
      atn_reg     <= atn_next;
      eoi_reg     <= eoi_next;
      remote_reg  <= remote_next;
      lockout_reg <= lockout_next;
      listen_reg  <= listen_next;
      talk_reg    <= talk_next;
      spoll_reg   <= spoll_next;
      clear_reg   <= clear_next;
      trig_reg    <= trig_next;
      dvalid_reg  <= dvalid_next;
      dout_reg    <= dout_next;
    end
  end

  assign nrfd_n_oe  = (hs_reg != gbc_pkg::GBC_HS_IDLE) || mg.dav
                      || (dvalid_reg && !mg.atn);
  assign nrfd_n_out = 1'b0;
  assign ndac_n_oe  = (hs_reg == gbc_pkg::GBC_HS_IDLE);
  assign ndac_n_out = 1'b0;
  assign srq_n_oe   = service_req;
  assign srq_n_out  = 1'b0;

  assign remote      = remote_reg;
  assign lockout     = lockout_reg;
  assign listener    = listen_reg;
  assign talker      = talk_reg;
  assign serial_poll = spoll_reg;
  assign dev_clear   = clear_reg;
  assign trigger     = trig_reg;
  assign data_valid  = dvalid_reg;
  assign data_out    = dout_reg;

  AST_DECODE_ONCE: assert property (@(posedge clk) disable iff (rst)
    decode_go |=> !decode_go [*2]) else $error("decode twice");
  AST_NDAC_AFTER_LATCH: assert property (@(posedge clk)
    disable iff (rst)
    $fell(ndac_n_oe) |-> $past(mg.dav) && byte_reg == $past(bus_data))
    else $error("ndac released early");
  AST_IFC_CLEARS: assert property (@(posedge clk) disable iff (rst)
    mg.ifc |=> !listen_reg && !talk_reg)
    else $error("ifc kept addressing");
  AST_UNL: assert property (@(posedge clk) disable iff (rst)
    decode_go && atn_reg && byte_reg[6:0] == `GBC_CMD_UNLISTEN
    |=> !listen_reg) else $error("unlisten ignored");
  AST_UNT: assert property (@(posedge clk) disable iff (rst)
    decode_go && atn_reg && byte_reg[6:0] == `GBC_CMD_UNTALK
    |=> !talk_reg) else $error("untalk ignored");
  AST_LLO: assert property (@(posedge clk) disable iff (rst)
    decode_go && atn_reg && byte_reg[6:0] == `GBC_CMD_LOCKOUT && mg.ren
    |=> lockout_reg) else $error("lockout ignored");
  AST_SPE: assert property (@(posedge clk) disable iff (rst)
    decode_go && atn_reg && byte_reg[6:0] == `GBC_CMD_POLL_ENABLE && !mg.ifc
    |=> spoll_reg) else $error("poll enable ignored");
  AST_SPD: assert property (@(posedge clk) disable iff (rst)
    decode_go && atn_reg && byte_reg[6:0] == `GBC_CMD_POLL_DISABLE
    |=> !spoll_reg) else $error("poll disable ignored");
  AST_DCL: assert property (@(posedge clk) disable iff (rst)
    decode_go && atn_reg && byte_reg[6:0] == `GBC_CMD_DEV_CLEAR
    |=> clear_reg ##1 !clear_reg) else $error("clear pulse bad");
  AST_DATA_FWD: assert property (@(posedge clk) disable iff (rst)
    decode_go && !atn_reg && listen_reg
    |=> data_valid && data_out.data == $past(byte_reg))
    else $error("data not forwarded");
  AST_SRQ: assert property (@(posedge clk) disable iff (rst)
    srq_n_oe == service_req && srq_n_out == 1'b0)
    else $error("srq mismatch");
endmodule
`default_nettype wire

// File: verif/gbc_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module gbc_ctrl_model (
  input  wire logic       clk,
  input  wire logic       nrfd_n_oe,
  input  wire logic       ndac_n_oe,
  output var  logic [7:0] dio_n,
  output var  logic       atn_n,
  output var  logic       ifc_n,
  output var  logic       ren_n,
  output var  logic       eoi_n,
  output var  logic       dav_n
);
  initial begin
    dio_n = 8'hFF;
    atn_n = 1'b1;
    ifc_n = 1'b1;
    ren_n = 1'b1;
    eoi_n = 1'b1;
    dav_n = 1'b1;
  end

  // wait for an acceptor line: sel 1 picks ndac, else nrfd
  task automatic wait_oe(input bit sel, input logic val, output bit ok);
    ok = 1'b0;
    for (int i = 0; i < 60 && !ok; i++) begin
      @(negedge clk);
      ok = ((sel ? ndac_n_oe : nrfd_n_oe) === val);
    end
    // act on the rising edge after the settled sample
    if (ok) begin
      @(posedge clk);
    end
  endtask

  // one byte, eoi with the last
  task automatic send_byte(input bit cmd, input logic [7:0] b,
                           input bit last, output bit ok);
    wait_oe(1'b0, 1'b0, ok);
    if (ok) begin
      dio_n <= ~b;
      atn_n <= ~cmd;
      eoi_n <= ~last;
      @(posedge clk);
      dav_n <= 1'b0;
      wait_oe(1'b1, 1'b0, ok);
      dav_n <= 1'b1;
      dio_n <= 8'hFF;
      eoi_n <= 1'b1;
      if (ok) begin
        wait_oe(1'b1, 1'b1, ok);
      end
    end
  endtask

  task automatic set_uni(input bit ren, input bit ifc);
    @(posedge clk);
    ren_n <= ~ren;
    ifc_n <= ~ifc;
    atn_n <= 1'b1;
  endtask
endmodule
`default_nettype wire

// File: verif/gbc_decoder_tb.sv
`timescale 1ns/1ps
`default_nettype none
module gbc_decoder_tb;
  logic               clk;
  logic               rst;
  logic               service_req;
  logic               parser_ready;
  logic [7:0]         dio_n;
  logic               atn_n;
  logic               ifc_n;
  logic               ren_n;
  logic               eoi_n;
  logic               dav_n;
  logic               nrfd_n_out;
  logic               nrfd_n_oe;
  logic               ndac_n_out;
  logic               ndac_n_oe;
  logic               srq_n_out;
  logic               srq_n_oe;
  logic               data_valid;
  gbc_pkg::gbc_byte_t data_out;
  logic               remote;
  logic               lockout;
  logic               listener;
  logic               talker;
  logic               serial_poll;
  logic               dev_clear;
  logic               trigger;
  logic [4:0]         paddr;
  int                 n_fail;
  int                 checked;
  int                 n_clr = 0;
  int                 n_trg = 0;

  gbc_ctrl_model ctrl (.clk(clk), .nrfd_n_oe(nrfd_n_oe),
    .ndac_n_oe(ndac_n_oe), .dio_n(dio_n), .atn_n(atn_n), .ifc_n(ifc_n),
    .ren_n(ren_n), .eoi_n(eoi_n), .dav_n(dav_n));

  gbc_decoder uut (.clk(clk), .rst(rst), .dio_n_in(dio_n), .atn_n(atn_n),
    .ifc_n(ifc_n), .ren_n(ren_n), .eoi_n_in(eoi_n), .dav_n(dav_n),
    .nrfd_n_out(nrfd_n_out), .nrfd_n_oe(nrfd_n_oe),
    .ndac_n_out(ndac_n_out), .ndac_n_oe(ndac_n_oe),
    .srq_n_out(srq_n_out), .srq_n_oe(srq_n_oe), .primary_addr(paddr),
    .service_req(service_req), .parser_ready(parser_ready),
    .data_valid(data_valid), .data_out(data_out), .remote(remote),
    .lockout(lockout), .listener(listener), .talker(talker),
    .serial_poll(serial_poll), .dev_clear(dev_clear), .trigger(trigger));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // count one-cycle pulses
  always @(posedge clk) begin
    if (dev_clear === 1'b1) n_clr++;
    if (trigger === 1'b1) n_trg++;
  end

  task automatic end_sim();
    $display("checked %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [8:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic tx(input bit cmd, input logic [7:0] b, input bit last);
    bit ok;
    ctrl.send_byte(cmd, b, last, ok);
    if (!ok) begin
      chk("handshake", {8'h00, ok}, 9'h001);
      end_sim();
    end
    cyc(3);
  endtask

  task automatic drain();
    @(posedge clk);
    parser_ready <= 1'b1;
    @(posedge clk);
    parser_ready <= 1'b0;
    cyc(2);
  endtask

  initial begin
    rst = 1'b1;
    service_req = 1'b0;
    parser_ready = 1'b0;
    paddr = 5'h0C;
    n_fail = 0;
    checked = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    cyc(2);
    chk("state", {remote, lockout, listener, talker, serial_poll, 4'h0},
        9'h000);
    chk("acceptor", {ndac_n_out, nrfd_n_out, ndac_n_oe, nrfd_n_oe},
        9'h002);
    tx(1, 8'h04, 0);
    tx(1, 8'h08, 0);
    chk("unaddressed", n_clr[8:0] + n_trg[8:0], 9'h000);
    ctrl.set_uni(1, 0);
    cyc(8);
    chk("remote", remote, 9'h001);
    tx(1, 8'h91, 0);
    chk("lockout", lockout, 9'h001);
    tx(1, 8'h3F, 0);
    tx(1, 8'h2C, 0);
    chk("listen", listener, 9'h001);
    tx(1, 8'h08, 0);
    chk("trigger", n_trg[8:0], 9'h001);
    tx(1, 8'h01, 0);
    chk("local", {remote, lockout}, 9'h000);
    tx(1, 8'h6C, 0);
    chk("secondary", {listener, talker}, 9'h002);
    ctrl.set_uni(1, 0);
    tx(0, 8'h46, 0);
    chk("valid", data_valid, 9'h001);
    chk("byte1", data_out, {8'h46, 1'b0});
    chk("hold off", nrfd_n_oe, 9'h001);
    drain();
    chk("drained", data_valid, 9'h000);
    tx(0, 8'h30, 1);
    chk("byte2", data_out, {8'h30, 1'b1});
    drain();
    tx(1, 8'h04, 0);
    chk("sel clear", n_clr[8:0], 9'h001);
    tx(1, 8'h3F, 0);
    chk("unlisten", listener, 9'h000);
    tx(1, 8'h14, 0);
    chk("dev clear", n_clr[8:0], 9'h002);
    tx(1, 8'h4C, 0);
    chk("talk", talker, 9'h001);
    tx(1, 8'h5F, 0);
    chk("untalk", talker, 9'h000);
    tx(1, 8'h18, 0);
    chk("poll on", serial_poll, 9'h001);
    tx(1, 8'h19, 0);
    chk("poll off", serial_poll, 9'h000);
    tx(1, 8'h2C, 0);
    tx(1, 8'h4C, 0);
    ctrl.set_uni(1, 1);
    cyc(8);
    ctrl.set_uni(1, 0);
    cyc(8);
    chk("clear", {listener, talker}, 9'h000);
    @(posedge clk);
    service_req <= 1'b1;
    cyc(3);
    chk("srq", {srq_n_oe, srq_n_out}, 9'h002);
    tx(1, 8'h4C, 0);
    chk("talk again", talker, 9'h001);
    // reset in mid-run drops all addressing and remote state
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    cyc(2);
    chk("reset", {remote, lockout, listener, talker, serial_poll, 4'h0},
        9'h000);
    chk("reset acceptor", {ndac_n_oe, nrfd_n_oe}, 9'h002);
    @(posedge clk);
    paddr <= 5'h03;
    tx(1, 8'h2C, 0);
    chk("old addr", listener, 9'h000);
    tx(1, 8'h23, 0);
    chk("new addr", listener, 9'h001);
    end_sim();
  end
endmodule
`default_nettype wire
